// ===== rtl/fnd_device.sv
// device end: serial registers, divider math, modulator and lock detect
//
// Summary of operation
// - bit 23 picks direct feedback source
// - bits 22..20 pick output divide ratio
// - mute output until lock when set
// - bit 5 enables primary rf output
// - bits 4..3 pick output power level
// - select 101 loads lock/detector register
// - host writes 00 antibacklash code
// - bit 29 enables charge cancellation
// - bits 23..22 pick lock pin function
// - host loads registers five down zero
// - output from int, fraction, divider
// - denominator 2..4095, dither needs 50
// - third-order modulator steps per pfd
// - repeat length from denominator factors
// - dither extends repeat to 2^21
// - host keeps pfd below 32 mhz
// - halving stage gives even duty
// - selects 100, 011, 010 load registers
// - lock after 40 or 5 good cycles
`timescale 1ns/1ps
module fnd_device
	import fnd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	fnd_if.dev link,
	input wire logic ref_edge_in,
	input wire logic phase_ok_in,
	output logic fb_direct_out,
	output logic [2:0] out_div_sel_out,
	output logic rf_on_out,
	output logic [1:0] rf_power_out,
	output logic charge_cancel_out,
	output logic abl_bad_out,
	output logic lock_indicator_pin_out,
	output logic pfd_tick_out,
	output logic [15:0] n_int_out,
	output logic [1:0] sd_carry_out,
	output logic den_bad_out,
	output logic [23:0] repeat_len_out
);
	import fnd_pkg::*;

	// ----------------------------------------------------------------
	// serial shift and latch
	// ----------------------------------------------------------------
	logic [31:0] shift_q;
	logic sclk_q, le_q;
	logic [31:0] reg_main_q, reg_fraction_numerator_q, reg_ref_q, reg_clk_q;
	logic [31:0] output_stage_config_q, lock_and_detector_config_q;
	logic le_rise;
	assign le_rise = link.load_en & ~le_q;

	// edge history of the pins
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_q <= 1'b0;
			le_q <= 1'b0;
		end else if (ce_in) begin
			sclk_q <= link.sclk;
			le_q <= link.load_en;
		end
	end

	// msb first, one bit per rising sclk
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shift_q <= 32'h0;
		end else if (ce_in && link.sclk && !sclk_q) begin
			shift_q <= {shift_q[30:0], link.sdata};
		end
	end

	// route whole word by its select bits on load rising edge
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_main_q <= 32'h0;
			reg_fraction_numerator_q <= 32'h0;
			reg_ref_q <= 32'h0;
			reg_clk_q <= 32'h0;
			output_stage_config_q <= 32'h0;
			lock_and_detector_config_q <= 32'h0;
		end else if (ce_in && le_rise) begin
			case (shift_q[2:0])
				SEL_MAIN: reg_main_q <= shift_q;
				SEL_FRACTION: reg_fraction_numerator_q <= shift_q;
				SEL_REFERENCE: reg_ref_q <= shift_q;
				SEL_CLOCK_DIV: reg_clk_q <= shift_q;
				SEL_OUTPUT_STAGE: output_stage_config_q <= shift_q;
				SEL_LOCK_DETECTOR: lock_and_detector_config_q <= shift_q;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// reference path: pfd tick generation
	// ----------------------------------------------------------------
	// the reference pulse stands in for the reference edge; doubler
	// takes both halves so each input pulse counts twice
	logic [9:0] rcount, r_cnt_q;
	logic r_pulse, half_q, doubler, halve;
	logic [1:0] ref_steps;
	assign rcount = reg_ref_q[RF_RCOUNT_HI:RF_RCOUNT_LO];
	assign doubler = reg_ref_q[RF_DOUBLER];
	assign halve = reg_ref_q[RF_HALVE];
	assign ref_steps = doubler ? 2'h2 : 2'h1;

	// r counter: pulse after r reference steps, zero treated as one
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			r_cnt_q <= 10'h0;
		end else if (ce_in && ref_edge_in) begin
			if ({1'b0, r_cnt_q} + {8'h0, ref_steps} >= {1'b0, rcount})
				r_cnt_q <= 10'h0;
			else
				r_cnt_q <= r_cnt_q + 10'(ref_steps);
		end
	end
	assign r_pulse = ref_edge_in &&
		({1'b0, r_cnt_q} + {8'h0, ref_steps} >= {1'b0, rcount});

	// halving toggle: passes every other pulse for even duty
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			half_q <= 1'b0;
			pfd_tick_out <= 1'b0;
		end else if (ce_in) begin
			if (r_pulse)
				half_q <= ~half_q;
			pfd_tick_out <= r_pulse && (!halve || half_q);
		end
	end

	// ----------------------------------------------------------------
	// third-order mash modulator, one step per pfd tick
	// ----------------------------------------------------------------
	logic [11:0] den, num;
	logic dither;
	logic [12:0] a1_q, a2_q, a3_q;
	logic [20:0] lfsr_q;
	logic c1_q, c2_q, c3_q, c2_dq, c3_dq, c3_ddq;
	assign den = reg_fraction_numerator_q[FR_DEN_HI:FR_DEN_LO];
	assign num = reg_main_q[MN_NUM_HI:MN_NUM_LO];
	assign dither = reg_ref_q[RF_LOW_SPUR_HI:RF_LOW_SPUR_LO] == NOISE_LOW_SPUR;

	// accumulate modulo den, giving carry
	function automatic logic [13:0] acc_step(input logic [12:0] a,
			input logic [12:0] add, input logic [11:0] m);
		logic [13:0] s;
		s = {1'b0, a} + {1'b0, add};
		if (s >= {2'b0, m})
			acc_step = {1'b1, 13'(s - {2'b0, m})};
		else
			acc_step = {1'b0, s[12:0]};
	endfunction

	// three cascaded stages; dither adds lfsr lsb to the first
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		logic [13:0] s1, s2, s3;
		if (!rstn_in) begin
			a1_q <= 13'h0;
			a2_q <= 13'h0;
			a3_q <= 13'h0;
			{c1_q, c2_q, c3_q, c2_dq, c3_dq, c3_ddq} <= 6'h0;
		end else if (ce_in && pfd_tick_out) begin
			s1 = acc_step(a1_q, {1'b0, num} + {12'h0, dither & lfsr_q[0]}, den);
			s2 = acc_step(a2_q, s1[12:0], den);
			s3 = acc_step(a3_q, s2[12:0], den);
			a1_q <= s1[12:0];
			a2_q <= s2[12:0];
			a3_q <= s3[12:0];
			c1_q <= s1[13];
			c2_q <= s2[13];
			c3_q <= s3[13];
			c2_dq <= c2_q;
			c3_dq <= c3_q;
			c3_ddq <= c3_dq;
		end
	end

	// dither source, 21-bit maximal sequence for 2^21 repeat
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lfsr_q <= 21'h1;
		end else if (ce_in && pfd_tick_out && dither) begin
			lfsr_q <= {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]};
		end
	end

	// n = int + c1 + (c2 - c2') + (c3 - 2c3' + c3''), low 2 bits shown
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		logic signed [3:0] d;
		if (!rstn_in) begin
			n_int_out <= 16'h0;
			sd_carry_out <= 2'h0;
		end else if (ce_in) begin
			d = 4'(c1_q) + 4'(c2_q) - 4'(c2_dq) + 4'(c3_q)
				- 4'(c3_dq) - 4'(c3_dq) + 4'(c3_ddq);
			n_int_out <= reg_main_q[MN_INT_HI:MN_INT_LO] + 16'(d);
			sd_carry_out <= d[1:0];
		end
	end

	// ----------------------------------------------------------------
	// repeat length and denominator limits
	// ----------------------------------------------------------------
	// divisibility by 3; one function keeps the 3x and 6x
	// cases from drifting apart
	function automatic logic div3(input logic [11:0] v);
		div3 = (v % 12'h003) == 12'h000;
	endfunction

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			repeat_len_out <= 24'h0;
			den_bad_out <= 1'b0;
		end else if (ce_in) begin
			if (dither)
				repeat_len_out <= {3'h0, DITHER_REPEAT_LAST} + 24'h1;
			else if (!den[0] && div3(den))
				repeat_len_out <= 24'(den) * 24'h6;
			else if (!den[0])
				repeat_len_out <= 24'(den) * 24'h2;
			else if (div3(den))
				repeat_len_out <= 24'(den) * 24'h3;
			else
				repeat_len_out <= 24'(den);
			den_bad_out <= (den < DEN_MIN) ||
				(dither && den < DEN_MIN_DITHER);
		end
	end

	// ----------------------------------------------------------------
	// digital lock detect and output stage
	// ----------------------------------------------------------------
	logic [5:0] good_q;
	logic locked_q;
	logic [5:0] need;
	assign need = reg_ref_q[RF_LOCK_COUNT_SELECT] ? LOCK_COUNT_SHORT
		: LOCK_COUNT_LONG;

	// count consecutive in-window pfd cycles; any miss restarts
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			good_q <= 6'h0;
			locked_q <= 1'b0;
		end else if (ce_in && pfd_tick_out) begin
			if (!phase_ok_in) begin
				good_q <= 6'h0;
				locked_q <= 1'b0;
			end else if (good_q + 6'h1 >= need) begin
				good_q <= need;
				locked_q <= 1'b1;
			end else begin
				good_q <= good_q + 6'h1;
			end
		end
	end

	// output stage controls, all registered
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fb_direct_out <= 1'b0;
			out_div_sel_out <= 3'h0;
			rf_on_out <= 1'b0;
			rf_power_out <= 2'h0;
			charge_cancel_out <= 1'b0;
			abl_bad_out <= 1'b0;
			lock_indicator_pin_out <= 1'b0;
		end else if (ce_in) begin
			fb_direct_out <= output_stage_config_q[OS_FB_DIRECT];
			out_div_sel_out <= output_stage_config_q[OS_DIV_HI:OS_DIV_LO];
			rf_on_out <= output_stage_config_q[OS_RF_ENABLE] &&
				(!output_stage_config_q[OS_MUTE_UNTIL_LOCKED] || locked_q);
			rf_power_out <= output_stage_config_q[OS_PWR_HI:OS_PWR_LO];
			charge_cancel_out <= lock_and_detector_config_q[LK_CHARGE_CANCEL];
			abl_bad_out <= lock_and_detector_config_q[LK_ABL_HI:LK_ABL_LO]
				!= ABL_4NS2;
			case (lock_and_detector_config_q[LK_PIN_HI:LK_PIN_LO])
				LDPIN_LOCK: lock_indicator_pin_out <= locked_q;
				LDPIN_HIGH: lock_indicator_pin_out <= 1'b1;
				default: lock_indicator_pin_out <= 1'b0;
			endcase
		end
	end
endmodule

// ===== shared/fnd_pkg.sv
// package: constants, field positions and types for the fractional-n serial link
package fnd_pkg;
	localparam int WORD_BITS = 32;
	// register select codes in the low three bits of each word
	localparam logic [2:0] SEL_MAIN = 3'h0;
	localparam logic [2:0] SEL_FRACTION = 3'h1;
	localparam logic [2:0] SEL_REFERENCE = 3'h2;
	localparam logic [2:0] SEL_CLOCK_DIV = 3'h3;
	localparam logic [2:0] SEL_OUTPUT_STAGE = 3'h4;
	localparam logic [2:0] SEL_LOCK_DETECTOR = 3'h5;
	// output stage fields
	localparam int OS_FB_DIRECT = 23;
	localparam int OS_DIV_HI = 22;
	localparam int OS_DIV_LO = 20;
	localparam int OS_MUTE_UNTIL_LOCKED = 10;
	localparam int OS_RF_ENABLE = 5;
	localparam int OS_PWR_HI = 4;
	localparam int OS_PWR_LO = 3;
	// lock and detector fields
	localparam int LK_ABL_HI = 31;
	localparam int LK_ABL_LO = 30;
	localparam int LK_CHARGE_CANCEL = 29;
	localparam int LK_PIN_HI = 23;
	localparam int LK_PIN_LO = 22;
	localparam logic [1:0] ABL_4NS2 = 2'h0;
	// reference register fields
	localparam int RF_LOW_SPUR_HI = 30;
	localparam int RF_LOW_SPUR_LO = 29;
	localparam logic [1:0] NOISE_LOW_SPUR = 2'h3;
	localparam int RF_DOUBLER = 25;
	localparam int RF_HALVE = 24;
	localparam int RF_RCOUNT_HI = 23;
	localparam int RF_RCOUNT_LO = 14;
	localparam int RF_LOCK_COUNT_SELECT = 8;
	// fraction register fields: denominator in bits 14..3
	localparam int FR_DEN_HI = 14;
	localparam int FR_DEN_LO = 3;
	// main register fields: integer 30..15, numerator 14..3
	localparam int MN_INT_HI = 30;
	localparam int MN_INT_LO = 15;
	localparam int MN_NUM_HI = 14;
	localparam int MN_NUM_LO = 3;
	localparam logic [11:0] DEN_MIN = 12'h002;
	localparam logic [11:0] DEN_MIN_DITHER = 12'h032;
	localparam logic [5:0] LOCK_COUNT_LONG = 6'h28;
	localparam logic [5:0] LOCK_COUNT_SHORT = 6'h05;
	localparam logic [20:0] DITHER_REPEAT_LAST = 21'h1FFFFF;
	// pfd limit in khz, kept for host checks
	localparam int PFD_MAX_KHZ = 32000;
	// host apb register offsets
	localparam logic [7:0] HA_DATA = 8'h00;
	localparam logic [7:0] HA_CTRL = 8'h04;
	localparam logic [7:0] HA_STATUS = 8'h08;
	// lock pin mode codes
	localparam logic [1:0] LDPIN_LOW = 2'h0;
	localparam logic [1:0] LDPIN_LOCK = 2'h1;
	localparam logic [1:0] LDPIN_LOW2 = 2'h2;
	localparam logic [1:0] LDPIN_HIGH = 2'h3;
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SHIFT = 2'b01,
		HS_LATCH = 2'b11,
		HS_DONE = 2'b10
	} fnd_host_state_t;
endpackage

// ===== shared/fnd_if.sv
// interface: three-wire serial port between host and synthesizer
`timescale 1ns/1ps
interface fnd_if;
	logic sclk;
	logic sdata;
	logic load_en;
	modport host (output sclk, output sdata, output load_en);
	modport dev (input sclk, input sdata, input load_en);
endinterface

// ===== rtl/fnd_host.sv
// host end: apb-programmed serial word sender
`timescale 1ns/1ps
module fnd_host
	import fnd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fnd_if.host link
);
	import fnd_pkg::*;

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	logic [31:0] data_q;
	logic [7:0] div_q;
	logic start;
	fnd_host_state_t st_q;
	logic [5:0] bit_q;
	logic [7:0] tick_q;
	logic [31:0] sh_q;
	logic sclk_q, sdata_q, le_q;
	logic [2:0] next_sel_q;
	logic order_err_q;
	logic init_done_q;
	logic busy;
	logic acc;
	assign busy = st_q != HS_IDLE;
	assign acc = psel && penable;
	assign start = acc && pwrite && paddr == HA_CTRL && pwdata[0] && !busy;

	// writes: data word and clock divider; zero-wait answer
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_q <= 32'h0;
			div_q <= 8'h1;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce_in) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr != HA_DATA &&
				paddr != HA_CTRL && paddr != HA_STATUS;
			if (acc && pready && pwrite && paddr == HA_DATA && !busy)
				data_q <= pwdata;
			if (acc && pready && pwrite && paddr == HA_CTRL)
				div_q <= pwdata[15:8];
			if (psel && !penable) begin
				case (paddr)
					HA_DATA: prdata <= data_q;
					HA_CTRL: prdata <= {16'h0, div_q, 8'h0};
					HA_STATUS: prdata <= {26'h0, order_err_q, next_sel_q,
						1'b0, busy};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// word sender, msb first, load pulse after last bit
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q <= HS_IDLE;
			bit_q <= 6'h0;
			tick_q <= 8'h0;
			sh_q <= 32'h0;
			sclk_q <= 1'b0;
			sdata_q <= 1'b0;
			le_q <= 1'b0;
		end else if (ce_in) begin
			case (st_q)
				HS_IDLE: begin
					le_q <= 1'b0;
					if (start && pready) begin
						sh_q <= data_q;
						sdata_q <= data_q[31];
						bit_q <= 6'h0;
						tick_q <= 8'h0;
						st_q <= HS_SHIFT;
					end
				end
				HS_SHIFT: begin
					if (tick_q >= div_q) begin
						tick_q <= 8'h0;
						sclk_q <= ~sclk_q;
						if (sclk_q) begin
							sh_q <= {sh_q[30:0], 1'b0};
							sdata_q <= sh_q[30];
							bit_q <= bit_q + 6'h1;
							if (bit_q == 6'(WORD_BITS - 1))
								st_q <= HS_LATCH;
						end
					end else begin
						tick_q <= tick_q + 8'h1;
					end
				end
				HS_LATCH: begin
					le_q <= 1'b1;
					st_q <= HS_DONE;
				end
				HS_DONE: begin
					le_q <= 1'b0;
					st_q <= HS_IDLE;
				end
				default: st_q <= HS_IDLE;
			endcase
		end
	end

	// order watch: after reset expect selects 5,4,...,0; once the
	// main word is in, later updates may come in any order
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			next_sel_q <= SEL_LOCK_DETECTOR;
			order_err_q <= 1'b0;
			init_done_q <= 1'b0;
		end else if (ce_in && start && pready) begin
			if (!init_done_q) begin
				if (data_q[2:0] != next_sel_q)
					order_err_q <= 1'b1;
				else if (next_sel_q == SEL_MAIN)
					init_done_q <= 1'b1;
				else
					next_sel_q <= next_sel_q - 3'h1;
			end
			if (data_q[2:0] == SEL_LOCK_DETECTOR &&
					data_q[LK_ABL_HI:LK_ABL_LO] != ABL_4NS2)
				order_err_q <= 1'b1;
		end
	end

	assign link.sclk = sclk_q;
	assign link.sdata = sdata_q;
	assign link.load_en = le_q;
endmodule

// ===== dv/fnd_link_chk.sv
// checker: serial word framing and causes of device output changes
`timescale 1ns/1ps
module fnd_link_chk (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_en,
	input wire logic fb_direct_out,
	input wire logic [2:0] out_div_sel_out,
	input wire logic [1:0] rf_power_out,
	input wire logic charge_cancel_out,
	input wire logic lock_indicator_pin_out,
	input wire logic rf_on_out
);
	logic sclk_q;
	logic load_q;
	logic [5:0] rise_cnt_q;
	logic [7:0] since_load_q;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	// ----
	// helpers
	// ----
	// clock rises since the last word; saturates so a runaway shows
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_q <= 1'b0;
			rise_cnt_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (load_en)
				rise_cnt_q <= 6'h00;
			else if (sclk && !sclk_q && rise_cnt_q != 6'h3F)
				rise_cnt_q <= rise_cnt_q + 6'h01;
		end
	end
	// cycles since load rose; starts saturated so reset values must hold
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			load_q <= 1'b0;
			since_load_q <= 8'hFF;
		end else begin
			load_q <= load_en;
			if (load_en && !load_q)
				since_load_q <= 8'h00;
			else if (since_load_q != 8'hFF)
				since_load_q <= since_load_q + 8'h01;
		end
	end

	// ----
	// properties
	// ----
	property p_load_pulse;
		$rose(load_en) |=> !load_en;
	endproperty
	a_load_pulse: assert property (p_load_pulse)
		else $error("load strobe held too long");
	property p_data_steady;
		$rose(sclk) |-> $stable(sdata);
	endproperty
	a_data_steady: assert property (p_data_steady)
		else $error("data moved on clock rise");
	property p_word_len;
		$rose(load_en) |-> rise_cnt_q == 6'h20;
	endproperty
	a_word_len: assert property (p_word_len)
		else $error("word not 32 clocks long");
	property p_bit_cap;
		rise_cnt_q <= 6'h20;
	endproperty
	a_bit_cap: assert property (p_bit_cap)
		else $error("more than 32 clocks in a word");
	property p_quiet_load;
		load_en |-> !$rose(sclk);
	endproperty
	a_quiet_load: assert property (p_quiet_load)
		else $error("clock rose during load");
	property p_fb_cause;
		$changed(fb_direct_out) |-> since_load_q <= 8'h06;
	endproperty
	a_fb_cause: assert property (p_fb_cause)
		else $error("feedback select changed without a word");
	property p_div_hold;
		since_load_q > 8'h06 |-> $stable(out_div_sel_out);
	endproperty
	a_div_hold: assert property (p_div_hold)
		else $error("divider select changed without a word");
	property p_pwr_cause;
		!$stable(rf_power_out) |-> $past(since_load_q) < 8'h06;
	endproperty
	a_pwr_cause: assert property (p_pwr_cause)
		else $error("power level changed without a word");
	property p_cc_cause;
		$rose(charge_cancel_out) |-> since_load_q <= 8'h06;
	endproperty
	a_cc_cause: assert property (p_cc_cause)
		else $error("charge cancel rose without a word");

	c_word: cover property ($rose(load_en));
	c_lock: cover property ($rose(lock_indicator_pin_out));
	c_rf_on: cover property ($rose(rf_on_out));
endmodule

// ===== dv/fraction_numerator_n_divider_output_config_bench.sv
// bench: host and device joined, driven over apb, outputs judged
`timescale 1ns/1ps
module fraction_numerator_n_divider_output_config_bench;
	import fnd_pkg::*;
	logic mclk_in, rstn_in, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic phase_ok_in, fb_direct_out, rf_on_out;
	logic ref_edge_in = 1'b0;
	logic charge_cancel_out, abl_bad_out, lock_indicator_pin_out;
	logic pfd_tick_out, den_bad_out;
	logic [2:0] out_div_sel_out;
	logic [1:0] rf_power_out, sd_carry_out;
	logic [1:0] ref_cnt_q = 2'h0;
	logic [15:0] n_int_out;
	logic [23:0] repeat_len_out;
	int n_mismatch, checked;
	fnd_if lnk();

	fnd_host fnd_host_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.ce_in(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lnk));
	fnd_device fnd_device_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.ce_in(1'b1), .link(lnk), .ref_edge_in(ref_edge_in),
		.phase_ok_in(phase_ok_in), .fb_direct_out(fb_direct_out),
		.out_div_sel_out(out_div_sel_out), .rf_on_out(rf_on_out),
		.rf_power_out(rf_power_out), .charge_cancel_out(charge_cancel_out),
		.abl_bad_out(abl_bad_out),
		.lock_indicator_pin_out(lock_indicator_pin_out),
		.pfd_tick_out(pfd_tick_out), .n_int_out(n_int_out),
		.sd_carry_out(sd_carry_out), .den_bad_out(den_bad_out),
		.repeat_len_out(repeat_len_out));
	fnd_link_chk fnd_link_chk_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.sclk(lnk.sclk), .sdata(lnk.sdata), .load_en(lnk.load_en),
		.fb_direct_out(fb_direct_out), .out_div_sel_out(out_div_sel_out),
		.rf_power_out(rf_power_out), .charge_cancel_out(charge_cancel_out),
		.lock_indicator_pin_out(lock_indicator_pin_out),
		.rf_on_out(rf_on_out));

	// ----
	// clock and reference
	// ----
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	// one reference edge every fourth cycle keeps ticks well apart
	// and the pfd rate at 10 mhz or less, far under its limit
	always @(posedge mclk_in) begin
		ref_cnt_q <= ref_cnt_q + 2'h1;
		ref_edge_in <= (ref_cnt_q == 2'h3);
	end

	// ----
	// shared tasks
	// ----
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		int n;
		@(posedge mclk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n == 40) n_mismatch++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// load a word, start it, poll busy, then let the device settle
	task automatic send(input logic [31:0] w);
		logic [31:0] q;
		logic e;
		int n;
		apb(1'b1, HA_DATA, w, q, e);
		apb(1'b1, HA_CTRL, 32'h0000_0101, q, e);
		n = 0;
		do begin
			apb(1'b0, HA_STATUS, 32'h0000_0000, q, e);
			n++;
		end while (q[0] !== 1'b0 && n < 400);
		if (n == 400) n_mismatch++;
		repeat (8) @(posedge mclk_in);
	endtask
	task automatic do_reset();
		rstn_in <= 1'b0;
		repeat (5) @(posedge mclk_in);
		rstn_in <= 1'b1;
	endtask
	task automatic wait_ticks(input int n);
		int t;
		t = 0;
		repeat (n) begin
			do begin
				@(posedge mclk_in);
				t++;
			end while (pfd_tick_out !== 1'b1 && t < 400);
		end
		if (t >= 400) n_mismatch++;
		repeat (2) @(posedge mclk_in);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_init();
		logic [31:0] w [6];
		logic [31:0] q;
		logic e;
		w[0] = (32'h1 << LK_CHARGE_CANCEL) | (32'(LDPIN_LOCK) << LK_PIN_LO);
		w[0] = w[0] | 32'(SEL_LOCK_DETECTOR);
		w[1] = (32'h1 << OS_FB_DIRECT) | (32'h3 << OS_DIV_LO);
		w[1] = w[1] | (32'h1 << OS_MUTE_UNTIL_LOCKED);
		w[1] = w[1] | (32'h1 << OS_RF_ENABLE) | (32'h2 << OS_PWR_LO);
		w[1] = w[1] | 32'(SEL_OUTPUT_STAGE);
		w[2] = 32'(SEL_CLOCK_DIV);
		w[3] = (32'h1 << RF_RCOUNT_LO) | (32'h1 << RF_LOCK_COUNT_SELECT);
		w[3] = w[3] | 32'(SEL_REFERENCE);
		w[4] = (32'h00A << FR_DEN_LO) | 32'(SEL_FRACTION);
		w[5] = (32'h0078 << MN_INT_LO) | 32'(SEL_MAIN);
		foreach (w[i]) send(w[i]);
		apb(1'b0, HA_STATUS, 32'h0000_0000, q, e);
		chk("order flag", 32'h0, 32'(q[5]));
		chk("feedback", 32'h1, 32'(fb_direct_out));
		chk("divider", 32'h3, 32'(out_div_sel_out));
		chk("power", 32'h2, 32'(rf_power_out));
		chk("muted output", 32'h0, 32'(rf_on_out));
		chk("charge cancel", 32'h1, 32'(charge_cancel_out));
		chk("antibacklash", 32'h0, 32'(abl_bad_out));
		chk("repeat even", 32'h14, 32'(repeat_len_out));
		chk("integer", 32'h78, 32'(n_int_out));
		chk("carry", 32'h0, 32'(sd_carry_out));
	endtask
	// five good cycles needed in short count mode
	task automatic t_lock();
		logic [31:0] q;
		logic e;
		phase_ok_in <= 1'b1;
		wait_ticks(4);
		chk("lock early", 32'h0, 32'(lock_indicator_pin_out));
		chk("mute early", 32'h0, 32'(rf_on_out));
		wait_ticks(2);
		chk("lock", 32'h1, 32'(lock_indicator_pin_out));
		chk("unmuted", 32'h1, 32'(rf_on_out));
		for (int m = 0; m < 4; m++) begin
			send((32'(m) << LK_PIN_LO) | (32'(m & 1) << LK_CHARGE_CANCEL)
				| 32'(SEL_LOCK_DETECTOR));
			chk("pin mode", 32'(m & 1), 32'(lock_indicator_pin_out));
			chk("cancel", 32'(m & 1), 32'(charge_cancel_out));
		end
		// reprogramming after a full start-up is not an order fault
		apb(1'b0, HA_STATUS, 32'h0000_0000, q, e);
		chk("order after init", 32'h0, 32'(q[5]));
	endtask
	task automatic t_out();
		logic [31:0] w;
		for (int i = 0; i < 4; i++) begin
			w = (32'(i & 1) << OS_FB_DIRECT) | (32'(7 - i) << OS_DIV_LO);
			w = w | (32'(i >> 1) << OS_RF_ENABLE) | (32'(i) << OS_PWR_LO);
			send(w | 32'(SEL_OUTPUT_STAGE));
			chk("feedback", 32'(i & 1), 32'(fb_direct_out));
			chk("divider", 32'(7 - i), 32'(out_div_sel_out));
			chk("enable", 32'(i >> 1), 32'(rf_on_out));
			chk("power", 32'(i), 32'(rf_power_out));
		end
	endtask
	task automatic t_mod();
		int den [7] = '{2, 9, 10, 12, 7, 4095, 1};
		int len [7] = '{4, 27, 20, 72, 7, 12285, 0};
		for (int i = 0; i < 7; i++) begin
			send((32'(den[i]) << FR_DEN_LO) | 32'(SEL_FRACTION));
			chk("den range", 32'(den[i] < 2), 32'(den_bad_out));
			if (den[i] > 1)
				chk("repeat", 32'(len[i]), 32'(repeat_len_out));
		end
		send((32'h3 << RF_LOW_SPUR_LO) | (32'h1 << RF_RCOUNT_LO)
			| (32'h1 << RF_LOCK_COUNT_SELECT) | 32'(SEL_REFERENCE));
		send((32'h28 << FR_DEN_LO) | 32'(SEL_FRACTION));
		chk("dither den 40", 32'h1, 32'(den_bad_out));
		send((32'h32 << FR_DEN_LO) | 32'(SEL_FRACTION));
		chk("dither den 50", 32'h0, 32'(den_bad_out));
		chk("dither repeat", 32'h0020_0000, 32'(repeat_len_out));
	endtask
	// r of 2 with halving: one tick per four reference edges
	task automatic t_pfd();
		int c;
		send((32'h2 << RF_RCOUNT_LO) | (32'h1 << RF_HALVE)
			| (32'h1 << RF_LOCK_COUNT_SELECT) | 32'(SEL_REFERENCE));
		// first pass finds a tick, second measures the gap to the next
		repeat (2) begin
			c = 0;
			do begin
				@(posedge mclk_in);
				c++;
			end while (pfd_tick_out !== 1'b1 && c < 100);
		end
		chk("pfd spacing", 32'h10, 32'(c));
	endtask
	// fresh reset, then refused and out-of-order traffic
	task automatic t_refuse();
		logic [31:0] q;
		logic e;
		do_reset();
		chk("feedback reset", 32'h0, 32'(fb_direct_out));
		apb(1'b0, 8'h0C, 32'h0000_0000, q, e);
		chk("unmapped error", 32'h1, 32'(e));
		apb(1'b0, HA_STATUS, 32'h0000_0000, q, e);
		chk("status reset", 32'h14, q & 32'h0000_003D);
		apb(1'b0, HA_CTRL, 32'h0000_0000, q, e);
		chk("ctrl reset", 32'h0000_0100, q & 32'h0000_FF00);
		send(32'(SEL_OUTPUT_STAGE));
		apb(1'b0, HA_STATUS, 32'h0000_0000, q, e);
		chk("order flag", 32'h1, 32'(q[5]));
		send((32'h1 << LK_ABL_LO) | 32'(SEL_LOCK_DETECTOR));
		chk("bad antibacklash", 32'h1, 32'(abl_bad_out));
	endtask

	// ----
	// sequence and verdict
	// ----
	task automatic print_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		rstn_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		phase_ok_in = 1'b0;
		n_mismatch = 0;
		checked = 0;
		do_reset();
		t_init();
		t_lock();
		t_out();
		t_mod();
		t_pfd();
		t_refuse();
		print_verdict();
	end
	// a hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge mclk_in);
		n_mismatch++;
		print_verdict();
	end
endmodule
